// ===== design/eisr_event_ctrl.sv
`timescale 1ns/1ps
// Summary of operation
// - Selector holds eleven function codes, zero to ten.
// - Code zero ignores the event; primary gains and setpoint source apply.
// - Alternate setpoint code uses second setpoint while event asserted.
// - Alternate gain code uses second band, integral, derivative while asserted.
// - Combined code switches setpoint and all gains together.
// - Alarm one clears on assertion, re-raises on release if condition holds.
// - Alarm two clears on assertion, re-raises on release if condition holds.
// - Dual code clears both alarms, re-raises those still present.
// - Inhibit codes force output one, two or both values to zero.
// - Inhibited outputs return to normal control immediately on release.
// - Lock code blocks all parameter changes while asserted.
// - Alternate setpoint is second value, or primary plus second in offset format.
// - Alternate setpoint honoured only in dual or ramp setpoint modes.
// - Ramp modes ramp working setpoint at power-up and on setpoint change.
// - Ramp starts from process value at power-up and on rate or setpoint change.
// - Zero ramp rate makes working setpoint follow target directly.
// - Lower display shows ramp value, target while an adjust key is pressed.
// - Alarm channel with timer function acts as dwell timer.
// - Timer starts when process reaches setpoint, alarm on expiry.
// - Duration changes do not restart count; expiry uses new duration.
// - Heater current sampled only while heater energised, else held.
// - Energised timer output stays until reset, event clear function, or timer function turned off on both alarm channels.
module eisr_event_ctrl #(
  parameter int unsigned DEBOUNCE_CYC = eisr_pkg::EISR_DEBOUNCE_CYC,
  parameter longint unsigned MINUTE_CYC = eisr_pkg::EISR_MINUTE_CYC,
  parameter longint unsigned HOUR_CYC = eisr_pkg::EISR_HOUR_CYC
) (
  input wire logic i_clk_sys,
  input wire logic i_reset_n,
  input wire logic i_event_in,
  input wire eisr_pkg::eisr_fn_t i_event_function_select,
  input wire eisr_pkg::eisr_spm_t i_setpoint_source_mode,
  input wire logic i_alt_setpoint_format,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_primary_setpoint,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_alternate_setpoint,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_remote_setpoint,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_process_value,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_ramp_rate,
  input wire logic i_adjust_key,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_first_prop_band,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_first_integral_time,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_first_derivative_time,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_second_prop_band,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_second_integral_time,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_second_derivative_time,
  input wire logic i_tune_done,
  input wire logic [eisr_pkg::EISR_MV_W-1:0] i_out_one_manipulated_value,
  input wire logic [eisr_pkg::EISR_MV_W-1:0] i_out_two_manipulated_value,
  input wire logic i_alarm_one_cond,
  input wire logic i_alarm_two_cond,
  input wire logic i_alarm_one_function,
  input wire logic i_alarm_two_function,
  input wire logic [eisr_pkg::EISR_TMR_W-1:0] i_timer_duration,
  input wire logic i_second_input_type,
  input wire logic i_heater_on,
  input wire logic [eisr_pkg::EISR_VAL_W-1:0] i_second_input_value,
  input wire logic i_param_write_req,
  output logic [eisr_pkg::EISR_VAL_W-1:0] o_working_setpoint,
  output logic [eisr_pkg::EISR_VAL_W-1:0] o_lower_display,
  output logic [eisr_pkg::EISR_VAL_W-1:0] o_prop_band,
  output logic [eisr_pkg::EISR_VAL_W-1:0] o_integral_time,
  output logic [eisr_pkg::EISR_VAL_W-1:0] o_derivative_time,
  output logic o_tune_store_first,
  output logic o_tune_store_second,
  output logic [eisr_pkg::EISR_MV_W-1:0] o_out_one_mv,
  output logic [eisr_pkg::EISR_MV_W-1:0] o_out_two_mv,
  output logic o_alarm_one,
  output logic o_alarm_two,
  output logic [eisr_pkg::EISR_VAL_W-1:0] o_heater_current,
  output logic o_param_write_en
);
  import eisr_pkg::*;

  logic rst_s1_q;
  logic rst_n_q;
  logic ev;
  logic alt_sp_sel;
  logic alt_gain_sel;
  logic alt_sp_ok;
  logic ramp_mode;
  logic [EISR_VAL_W-1:0] alt_sp;
  logic [EISR_VAL_W-1:0] target;
  logic [EISR_VAL_W-1:0] target_q;
  logic [EISR_VAL_W-1:0] rate_q;
  logic [EISR_VAL_W-1:0] ramp_q;
  logic [63:0] tick_cnt_q;
  logic [63:0] tick_len;
  logic init_q;
  logic [EISR_TMR_W-1:0] dwell_cnt_q;
  logic [63:0] dwell_tick_q;
  logic dwell_run_q;
  logic dwell_done_q;
  logic clr_a1;
  logic clr_a2;
  logic inh_o1;
  logic inh_o2;

  // Reset release through two flops
  always_ff @(posedge i_clk_sys or negedge i_reset_n)
  begin
    if (!i_reset_n)
    begin
      rst_s1_q <= 1'b0;
      rst_n_q <= 1'b0;
    end
    else
    begin
      rst_s1_q <= 1'b1;
      rst_n_q <= rst_s1_q;
    end
  end

  eisr_event_filter #(
    .STABLE_CYC(DEBOUNCE_CYC)
  ) u_filter (
    .i_clk(i_clk_sys),
    .i_rst_n(rst_n_q),
    .i_raw(i_event_in),
    .o_level(ev),
    .o_rise(),
    .o_fall()
  );

  // Function decode; code zero and unknown codes select nothing
  always_comb
  begin
    alt_sp_sel = 1'b0;
    alt_gain_sel = 1'b0;
    clr_a1 = 1'b0;
    clr_a2 = 1'b0;
    inh_o1 = 1'b0;
    inh_o2 = 1'b0;
    case (i_event_function_select)
      EISR_FN_ALT_SP: alt_sp_sel = ev;
      EISR_FN_ALT_GAIN: alt_gain_sel = ev;
      EISR_FN_COMBINED:
      begin
        alt_sp_sel = ev;
        alt_gain_sel = ev;
      end
      EISR_FN_CLR_A1: clr_a1 = ev;
      EISR_FN_CLR_A2: clr_a2 = ev;
      EISR_FN_CLR_A12:
      begin
        clr_a1 = ev;
        clr_a2 = ev;
      end
      EISR_FN_INH_O1: inh_o1 = ev;
      EISR_FN_INH_O2: inh_o2 = ev;
      EISR_FN_INH_O12:
      begin
        inh_o1 = ev;
        inh_o2 = ev;
      end
      default:
      begin
      end
    endcase
  end

  assign ramp_mode = (i_setpoint_source_mode == EISR_SPM_RAMP_MIN)
    || (i_setpoint_source_mode == EISR_SPM_RAMP_HOUR);
  assign alt_sp_ok = ramp_mode || (i_setpoint_source_mode == EISR_SPM_DUAL);
  assign alt_sp = i_alt_setpoint_format ? (i_primary_setpoint + i_alternate_setpoint)
    : i_alternate_setpoint;

  always_comb
  begin
    if (alt_sp_sel && alt_sp_ok)
      target = alt_sp;
    else if (i_setpoint_source_mode == EISR_SPM_REMOTE)
      target = i_remote_setpoint;
    else
      target = i_primary_setpoint;
  end

  assign tick_len = (i_setpoint_source_mode == EISR_SPM_RAMP_HOUR) ? HOUR_CYC : MINUTE_CYC;

  // Ramp generator, steps by the ramp rate once per minute or hour
  always_ff @(posedge i_clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      init_q <= 1'b1;
      target_q <= '0;
      rate_q <= '0;
      ramp_q <= '0;
      tick_cnt_q <= 64'h0;
    end
    else
    begin
      init_q <= 1'b0;
      target_q <= target;
      rate_q <= i_ramp_rate;
      if (init_q || target != target_q || i_ramp_rate != rate_q)
      begin
        ramp_q <= i_process_value;
        tick_cnt_q <= 64'h0;
      end
      else if (tick_cnt_q >= tick_len - 64'h1)
      begin
        tick_cnt_q <= 64'h0;
        if (ramp_q < target_q)
          ramp_q <= (target_q - ramp_q > rate_q) ? ramp_q + rate_q : target_q;
        else
          ramp_q <= (ramp_q - target_q > rate_q) ? ramp_q - rate_q : target_q;
      end
      else
      begin
        tick_cnt_q <= tick_cnt_q + 64'h1;
      end
    end
  end

  // Working setpoint, gain set and display
  always_ff @(posedge i_clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_working_setpoint <= '0;
      o_lower_display <= '0;
      o_prop_band <= '0;
      o_integral_time <= '0;
      o_derivative_time <= '0;
    end
    else
    begin
      if (ramp_mode && i_ramp_rate != '0 && !init_q)
        o_working_setpoint <= ramp_q;
      else
        o_working_setpoint <= target;
      if (ramp_mode && i_ramp_rate != '0 && !i_adjust_key)
        o_lower_display <= ramp_q;
      else
        o_lower_display <= target;
      o_prop_band <= alt_gain_sel ? i_second_prop_band : i_first_prop_band;
      o_integral_time <= alt_gain_sel ? i_second_integral_time : i_first_integral_time;
      o_derivative_time <= alt_gain_sel ? i_second_derivative_time : i_first_derivative_time;
    end
  end

  assign o_tune_store_first = i_tune_done && !alt_gain_sel;
  assign o_tune_store_second = i_tune_done && alt_gain_sel;

  // Output inhibit, registered release on the next clock
  always_ff @(posedge i_clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_out_one_mv <= '0;
      o_out_two_mv <= '0;
    end
    else
    begin
      o_out_one_mv <= inh_o1 ? '0 : i_out_one_manipulated_value;
      o_out_two_mv <= inh_o2 ? '0 : i_out_two_manipulated_value;
    end
  end

  // Dwell timer, counts minutes once setpoint reached
  always_ff @(posedge i_clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      dwell_run_q <= 1'b0;
      dwell_done_q <= 1'b0;
      dwell_cnt_q <= '0;
      dwell_tick_q <= 64'h0;
    end
    else if (!(i_alarm_one_function || i_alarm_two_function))
    begin
      dwell_run_q <= 1'b0;
      dwell_done_q <= 1'b0;
      dwell_cnt_q <= '0;
      dwell_tick_q <= 64'h0;
    end
    else
    begin
      if ((i_alarm_one_function && clr_a1) || (i_alarm_two_function && clr_a2))
        dwell_done_q <= 1'b0;
      if (!dwell_run_q && !dwell_done_q && i_process_value >= o_working_setpoint)
      begin
        dwell_run_q <= 1'b1;
        dwell_cnt_q <= '0;
        dwell_tick_q <= 64'h0;
      end
      if (dwell_run_q)
      begin
        if (dwell_cnt_q >= i_timer_duration)
        begin
          dwell_done_q <= 1'b1;
          dwell_run_q <= 1'b0;
        end
        else if (dwell_tick_q >= MINUTE_CYC - 64'h1)
        begin
          dwell_tick_q <= 64'h0;
          dwell_cnt_q <= dwell_cnt_q + 1'b1;
        end
        else
          dwell_tick_q <= dwell_tick_q + 64'h1;
      end
    end
  end

  // Alarm outputs: held clear while event asserted, re-raised on release
  always_ff @(posedge i_clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
    begin
      o_alarm_one <= 1'b0;
      o_alarm_two <= 1'b0;
    end
    else
    begin
      if (clr_a1)
        o_alarm_one <= 1'b0;
      else
        o_alarm_one <= i_alarm_one_function ? dwell_done_q : i_alarm_one_cond;
      if (clr_a2)
        o_alarm_two <= 1'b0;
      else
        o_alarm_two <= i_alarm_two_function ? dwell_done_q : i_alarm_two_cond;
    end
  end

  // Heater current hold
  always_ff @(posedge i_clk_sys or negedge rst_n_q)
  begin
    if (!rst_n_q)
      o_heater_current <= '0;
    else if (i_second_input_type && i_heater_on)
      o_heater_current <= i_second_input_value;
  end

  assign o_param_write_en = i_param_write_req
    && !(ev && i_event_function_select == EISR_FN_LOCK);

  property p_inhibit_one;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    inh_o1 |=> (o_out_one_mv == '0);
  endproperty
  a_inhibit_one: assert property (p_inhibit_one) else $error("out one not zero");

  property p_release_one;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    !inh_o1 |=> (o_out_one_mv == $past(i_out_one_manipulated_value));
  endproperty
  a_release_one: assert property (p_release_one) else $error("out one not restored");

  property p_lock;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    (ev && i_event_function_select == EISR_FN_LOCK) |-> !o_param_write_en;
  endproperty
  a_lock: assert property (p_lock) else $error("write while locked");

  property p_clear_a1;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    clr_a1 |=> !o_alarm_one;
  endproperty
  a_clear_a1: assert property (p_clear_a1) else $error("alarm one not cleared");

  property p_clear_a2;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    clr_a2 |=> !o_alarm_two;
  endproperty
  a_clear_a2: assert property (p_clear_a2) else $error("alarm two not cleared");

  property p_gain_alt;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    alt_gain_sel |=> (o_prop_band == $past(i_second_prop_band));
  endproperty
  a_gain_alt: assert property (p_gain_alt) else $error("second band not used");

  property p_tune_store;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    i_tune_done |-> (o_tune_store_first != o_tune_store_second);
  endproperty
  a_tune_store: assert property (p_tune_store) else $error("tune store wrong");

  sequence s_heater_off;
    !(i_second_input_type && i_heater_on);
  endsequence
  property p_heater_hold;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    s_heater_off |=> (o_heater_current == $past(o_heater_current));
  endproperty
  a_heater_hold: assert property (p_heater_hold) else $error("heater value moved");

  property p_dwell_latch;
    @(posedge i_clk_sys) disable iff (!rst_n_q)
    (dwell_done_q && !clr_a1 && !clr_a2 && (i_alarm_one_function || i_alarm_two_function))
      |=> dwell_done_q;
  endproperty
  a_dwell_latch: assert property (p_dwell_latch) else $error("dwell output dropped");
endmodule

// ===== include/eisr_pkg.sv
package eisr_pkg;
  typedef enum logic [3:0] {
    EISR_FN_NONE,
    EISR_FN_ALT_SP,
    EISR_FN_ALT_GAIN,
    EISR_FN_COMBINED,
    EISR_FN_CLR_A1,
    EISR_FN_CLR_A2,
    EISR_FN_CLR_A12,
    EISR_FN_INH_O1,
    EISR_FN_INH_O2,
    EISR_FN_INH_O12,
    EISR_FN_LOCK
  } eisr_fn_t;
  typedef enum logic [2:0] {
    EISR_SPM_PRIMARY,
    EISR_SPM_DUAL,
    EISR_SPM_RAMP_MIN,
    EISR_SPM_RAMP_HOUR,
    EISR_SPM_REMOTE
  } eisr_spm_t;
  localparam int unsigned EISR_VAL_W = 16;
  localparam int unsigned EISR_MV_W = 12;
  localparam int unsigned EISR_TMR_W = 16;
  localparam int unsigned EISR_CLK_HZ = 200000000;
  localparam int unsigned EISR_DEBOUNCE_US = 50;
  localparam int unsigned EISR_DEBOUNCE_CYC = EISR_DEBOUNCE_US * (EISR_CLK_HZ / 1000000);
  localparam longint unsigned EISR_MINUTE_CYC = 64'd60 * EISR_CLK_HZ;
  localparam longint unsigned EISR_HOUR_CYC = 64'd3600 * EISR_CLK_HZ;
endpackage

// ===== design/eisr_event_filter.sv
`timescale 1ns/1ps
module eisr_event_filter #(
  parameter int unsigned STABLE_CYC = 16
) (
  input wire logic i_clk,
  input wire logic i_rst_n,
  input wire logic i_raw,
  output logic o_level,
  output logic o_rise,
  output logic o_fall
);
  logic sync1_q;
  logic sync2_q;
  logic [31:0] cnt_q;
  logic level_q;

  // Two-flop synchroniser
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
    end
    else
    begin
      sync1_q <= i_raw;
      sync2_q <= sync1_q;
    end
  end

  // Level accepted after stable period
  always_ff @(posedge i_clk or negedge i_rst_n)
  begin
    if (!i_rst_n)
    begin
      cnt_q <= 32'h0;
      level_q <= 1'b0;
    end
    else if (sync2_q == level_q)
    begin
      cnt_q <= 32'h0;
    end
    else if (cnt_q >= STABLE_CYC - 1)
    begin
      cnt_q <= 32'h0;
      level_q <= sync2_q;
    end
    else
    begin
      cnt_q <= cnt_q + 32'h1;
    end
  end

  assign o_level = level_q;
  assign o_rise = (sync2_q != level_q) && (cnt_q >= STABLE_CYC - 1) && sync2_q;
  assign o_fall = (sync2_q != level_q) && (cnt_q >= STABLE_CYC - 1) && !sync2_q;

  property p_rise_once;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_rise |=> (o_level && !o_rise);
  endproperty
  a_rise_once: assert property (p_rise_once) else $error("event rise not taken once");

  property p_fall_once;
    @(posedge i_clk) disable iff (!i_rst_n)
    o_fall |=> (!o_level && !o_fall);
  endproperty
  a_fall_once: assert property (p_fall_once) else $error("event fall not taken once");

  property p_level_hold;
    @(posedge i_clk) disable iff (!i_rst_n)
    (!o_rise && !o_fall) |=> (o_level == $past(o_level));
  endproperty
  a_level_hold: assert property (p_level_hold) else $error("event level moved without edge");
endmodule

// ===== verif/eisr_switch_model.sv
`timescale 1ns/1ps
module eisr_switch_model (
  input wire logic i_clk,
  input wire logic i_level,
  input wire logic i_bounce,
  output logic o_contact
);
  int chatter = 0;
  logic last = 1'b0;
  initial o_contact = 1'b0;
  // Contact follows the commanded level, optionally chattering one-cycle pulses
  always @(posedge i_clk)
  begin
    if (i_level !== last)
    begin
      last <= i_level;
      o_contact <= i_level;
      chatter <= i_bounce ? 6 : 0;
    end
    else if (chatter > 0)
    begin
      chatter <= chatter - 1;
      o_contact <= (chatter == 1) ? last : ~o_contact;
    end
  end
endmodule

// ===== verif/test_event_input_setpoint_ramp.sv
`timescale 1ns/1ps
module test_event_input_setpoint_ramp;
  import eisr_pkg::*;
  logic clk, rst_n, ev_lvl, ev_bounce, ev_pin, fmt, key, tune, ac1, ac2, af1, af2;
  logic htype, hon, wreq, st1, st2, al1, al2, wen;
  eisr_fn_t fn;
  eisr_spm_t spm;
  logic [15:0] sp1, sp2, rsp, pv, rate, pb1, ti1, td1, pb2, ti2, td2, tmr, hv;
  logic [15:0] ws, ld, pb, ti, td, hcur;
  logic [11:0] mv1, mv2, om1, om2;
  eisr_spm_t m_tab [4] = '{EISR_SPM_PRIMARY, EISR_SPM_DUAL, EISR_SPM_DUAL, EISR_SPM_REMOTE};
  int n_mismatch = 0;
  int checked = 0;
  int cyc = 0;
  int h_exp = 0;

  eisr_switch_model sw (.i_clk(clk), .i_level(ev_lvl), .i_bounce(ev_bounce), .o_contact(ev_pin));

  eisr_event_ctrl #(.DEBOUNCE_CYC(4), .MINUTE_CYC(20), .HOUR_CYC(40)) dut (
    .i_clk_sys(clk), .i_reset_n(rst_n), .i_event_in(ev_pin),
    .i_event_function_select(fn), .i_setpoint_source_mode(spm),
    .i_alt_setpoint_format(fmt), .i_primary_setpoint(sp1), .i_alternate_setpoint(sp2),
    .i_remote_setpoint(rsp), .i_process_value(pv), .i_ramp_rate(rate), .i_adjust_key(key),
    .i_first_prop_band(pb1), .i_first_integral_time(ti1), .i_first_derivative_time(td1),
    .i_second_prop_band(pb2), .i_second_integral_time(ti2), .i_second_derivative_time(td2),
    .i_tune_done(tune), .i_out_one_manipulated_value(mv1), .i_out_two_manipulated_value(mv2),
    .i_alarm_one_cond(ac1), .i_alarm_two_cond(ac2), .i_alarm_one_function(af1),
    .i_alarm_two_function(af2), .i_timer_duration(tmr), .i_second_input_type(htype),
    .i_heater_on(hon), .i_second_input_value(hv), .i_param_write_req(wreq),
    .o_working_setpoint(ws), .o_lower_display(ld), .o_prop_band(pb), .o_integral_time(ti),
    .o_derivative_time(td), .o_tune_store_first(st1), .o_tune_store_second(st2),
    .o_out_one_mv(om1), .o_out_two_mv(om2), .o_alarm_one(al1), .o_alarm_two(al2),
    .o_heater_current(hcur), .o_param_write_en(wen)
  );

  initial
  begin
    clk = 1'b0;
    forever #2.5 clk = ~clk;
  end

  task automatic final_report();
    if (n_mismatch == 0 && checked > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask

  task automatic check(input logic [15:0] seen, input logic [15:0] exp);
    checked++;
    if (seen !== exp)
    begin
      n_mismatch++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge clk);
    @(negedge clk);
  endtask

  task automatic check_all(input int f, input bit ev);
    logic [15:0] alt;
    logic [15:0] base;
    bit ua;
    bit g2;
    alt = fmt ? sp1 + sp2 : sp2;
    base = (spm == EISR_SPM_REMOTE) ? rsp : sp1;
    ua = ev && (f == 1 || f == 3) && spm == EISR_SPM_DUAL;
    g2 = ev && (f == 2 || f == 3);
    if (hon && htype)
      h_exp = hv;
    check(ws, ua ? alt : base);
    check(pb, g2 ? pb2 : pb1);
    check(ti, g2 ? ti2 : ti1);
    check(td, g2 ? td2 : td1);
    check({14'd0, st2, st1}, {14'd0, tune && g2, tune && !g2});
    check({4'd0, om1}, (ev && (f == 7 || f == 9)) ? 16'd0 : {4'd0, mv1});
    check({4'd0, om2}, (ev && (f == 8 || f == 9)) ? 16'd0 : {4'd0, mv2});
    check({15'd0, al1}, {15'd0, ac1 && !(ev && (f == 4 || f == 6))});
    check({15'd0, al2}, {15'd0, ac2 && !(ev && (f == 5 || f == 6))});
    check({15'd0, wen}, {15'd0, wreq && !(ev && f == 10)});
    check(hcur, h_exp[15:0]);
  endtask

  always @(posedge clk)
  begin
    cyc <= cyc + 1;
    if (cyc == 3000)
    begin
      n_mismatch++;
      final_report();
    end
  end

  initial
  begin
    {rst_n, ev_lvl, ev_bounce, fmt, key, tune, ac1, ac2, af1, af2, hon, wreq} = '0;
    htype = 1'b1;
    fn = EISR_FN_NONE;
    spm = EISR_SPM_PRIMARY;
    {sp1, sp2, rsp, pv, rate, pb1, ti1, td1, pb2, ti2, td2, hv} = '0;
    tmr = 16'd3;
    {mv1, mv2} = '0;
    void'($urandom(32'hc006a78f));
    repeat (3) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    // Every function code: idle, asserted, released
    for (int f = 0; f <= 10; f++)
    begin
      for (int e = 0; e < 3; e++)
      begin
        @(posedge clk);
        fn <= eisr_fn_t'(f);
        ev_lvl <= (e == 1);
        ev_bounce <= 1'($urandom);
        spm <= m_tab[$urandom_range(0, 3)];
        fmt <= 1'($urandom);
        {sp1, sp2} <= $urandom;
        {rsp, pb1} <= $urandom;
        {ti1, td1} <= $urandom;
        {pb2, ti2} <= $urandom;
        {td2, hv} <= $urandom;
        {mv1, mv2} <= 24'($urandom);
        {tune, ac2, wreq} <= 3'($urandom);
        ac1 <= (e == 1) ? 1'b1 : 1'($urandom);
        hon <= (f == 0 && e == 0) ? 1'b1 : 1'($urandom);
        htype <= (f == 0 && e == 0) ? 1'b1 : 1'($urandom);
        settle(20);
        check_all(f, e == 1);
      end
    end
    // Ramp behaviour
    @(posedge clk);
    fn <= EISR_FN_NONE;
    ev_lvl <= 1'b0;
    spm <= EISR_SPM_RAMP_MIN;
    pv <= 16'd100;
    sp1 <= 16'd100;
    settle(20);
    check(ws, 16'd100);
    @(posedge clk);
    sp1 <= 16'd150;
    rate <= 16'd10;
    settle(45);
    check({15'd0, ws >= 16'd100 && ws < 16'd150}, 16'd1);
    @(posedge clk);
    key <= 1'b1;
    settle(3);
    check(ld, 16'd150);
    @(posedge clk);
    key <= 1'b0;
    settle(120);
    check(ws, 16'd150);
    check(ld, 16'd150);
    @(posedge clk);
    pv <= 16'd300;
    sp1 <= 16'd200;
    settle(30);
    check(ws, 16'd290);
    @(posedge clk);
    rate <= 16'd0;
    settle(5);
    check(ws, 16'd200);
    @(posedge clk);
    spm <= EISR_SPM_RAMP_HOUR;
    fn <= EISR_FN_ALT_SP;
    fmt <= 1'b0;
    sp2 <= 16'd250;
    ev_lvl <= 1'b1;
    settle(20);
    check(ws, 16'd250);
    // Dwell timer on alarm channel one
    @(posedge clk);
    ev_lvl <= 1'b0;
    fn <= EISR_FN_NONE;
    spm <= EISR_SPM_PRIMARY;
    sp1 <= 16'd500;
    pv <= 16'd0;
    ac1 <= 1'b0;
    af1 <= 1'b1;
    settle(20);
    check({15'd0, al1}, 16'd0);
    @(posedge clk);
    pv <= 16'd500;
    settle(15);
    check({15'd0, al1}, 16'd0);
    @(posedge clk);
    tmr <= 16'd2;
    settle(35);
    check({15'd0, al1}, 16'd1);
    @(posedge clk);
    pv <= 16'd0;
    tmr <= 16'd100;
    settle(20);
    check({15'd0, al1}, 16'd1);
    @(posedge clk);
    fn <= EISR_FN_CLR_A1;
    ev_lvl <= 1'b1;
    settle(20);
    check({15'd0, al1}, 16'd0);
    // Dwell timer on alarm channel two, restarted from zero
    @(posedge clk);
    ev_lvl <= 1'b0;
    fn <= EISR_FN_NONE;
    af1 <= 1'b0;
    af2 <= 1'b1;
    ac2 <= 1'b0;
    pv <= 16'd500;
    tmr <= 16'd2;
    settle(30);
    check({14'd0, al2, al1}, 16'd0);
    settle(20);
    check({14'd0, al2, al1}, 16'd2);
    @(posedge clk);
    fn <= EISR_FN_CLR_A2;
    ev_lvl <= 1'b1;
    settle(20);
    check({15'd0, al2}, 16'd0);
    final_report();
  end
endmodule
